// *** core/iwg_pkg.sv ***
// Constants and types for the inverted-pair write guard.
package iwg_pkg;
    // Serial frame layout and length bookkeeping.
    localparam int         FRAME_BITS = 16;
    localparam logic [4:0] LEN_OK     = 5'h10;
    localparam logic [4:0] LEN_SAT    = 5'h11;

    // Addresses of the two guarded register pairs.
    localparam logic [5:0] ADDR_SRR     = 6'h01;
    localparam logic [5:0] ADDR_SRR_INV = 6'h02;
    localparam logic [5:0] ADDR_PVR     = 6'h03;
    localparam logic [5:0] ADDR_PVR_INV = 6'h04;

    // Field positions inside the request bytes.
    localparam int ST_LSB     = 0;
    localparam int ST_W       = 3;
    localparam int RAIL_LSB   = 3;
    localparam int RAIL_W     = 5;
    localparam int VSEL_LSB   = 0;
    localparam int VSEL_W     = 4;
    localparam int ST_CODES   = 8;
    localparam int VSEL_CODES = 16;

    // Values after reset.
    localparam logic [RAIL_W-1:0] RAIL_RST = 5'h00;
    localparam logic [VSEL_W-1:0] VSEL_RST = 4'h0;
    localparam logic [ST_W-1:0]   ST_RST   = 3'h0;

    // Longest frame, with chip select low.
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_FRAME_NS    = 1850000;
    localparam int FRAME_MAX_CYC = T_FRAME_NS / CLK_PERIOD_NS;
    localparam int TMO_W         = 17;

    typedef enum logic [1:0] {
        IWG_IDLE     = 2'b00,
        IWG_SRR_HELD = 2'b01,
        IWG_PVR_HELD = 2'b11
    } iwg_pend_t;

    typedef struct packed {
        logic       cmd;
        logic [5:0] addr;
        logic [7:0] data;
        logic       par;
    } iwg_frame_t;

    typedef struct packed {
        logic dur;
        logic len;
        logic par;
        logic volt;
        logic srr;
    } iwg_flags_t;

    typedef struct packed {
        logic              cs_s1;
        logic              cs_s2;
        logic              cs_d;
        logic              cs_d2;
        logic              tg_s1;
        logic              tg_s2;
        logic              tg_d;
        logic [4:0]        bit_cnt;
        logic [TMO_W-1:0]  tmo_cnt;
        logic              timed_out;
        iwg_pend_t         pend;
        logic [7:0]        held;
        logic [RAIL_W-1:0] rail;
        logic [ST_W-1:0]   st_code;
        logic              st_req;
        logic [VSEL_W-1:0] vsel;
        iwg_flags_t        flags;
        logic              int_n;
        logic              out_en;
    } iwg_core_t;

    typedef struct packed {
        logic        rst_s1;
        logic        rst_s2;
        logic [15:0] shift;
        logic        tgl;
        logic        out_bit;
    } iwg_link_t;

    localparam iwg_core_t CORE_RST = '{cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1, cs_d2: 1'b1,
                                       pend: IWG_IDLE, rail: RAIL_RST, vsel: VSEL_RST,
                                       st_code: ST_RST, int_n: 1'b1, default: '0};
    localparam iwg_link_t LINK_RST = '0;
endpackage

// *** core/iwg_top.sv ***
// Inverted-pair write guard for the two serially written request pairs.
`timescale 1ns/1ps
`default_nettype none
module iwg_top #(
    parameter int FRAME_MAX = iwg_pkg::FRAME_MAX_CYC
) (
    // System clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  rst_n,
    // Serial link
    input  wire logic                                  sclk,
    input  wire logic                                  frame_select_pin,
    input  wire logic                                  serial_in_pin,
    output logic                                       serial_out_pin,
    output logic                                       serial_out_pin_oe,
    // State machine and regulator side
    input  wire logic [iwg_pkg::ST_CODES-1:0]          transition_allowed,
    input  wire logic [iwg_pkg::VSEL_CODES-1:0]        voltage_code_allowed,
    output logic                                       state_request_pulse,
    output logic [iwg_pkg::ST_W-1:0]                   state_request_code,
    output logic [iwg_pkg::RAIL_W-1:0]                 rail_config,
    output logic [iwg_pkg::VSEL_W-1:0]                 voltage_select_field,
    // Status
    input  wire iwg_pkg::iwg_flags_t                   flag_clear,
    output iwg_pkg::iwg_flags_t                        serial_error_flags,
    output logic                                       int_n
);
    import iwg_pkg::*;

    iwg_core_t         r;
    iwg_core_t         n;
    iwg_link_t         l;
    iwg_link_t         l_n;
    iwg_frame_t        fr;
    iwg_flags_t        set;
    logic              eval;
    logic              len_ok;
    logic              par_ok;
    logic              wr_ok;
    logic              is_srr;
    logic              is_srr_inv;
    logic              is_pvr;
    logic              is_pvr_inv;
    logic              srr_match;
    logic              pvr_match;
    logic              commit_s;
    logic              commit_v;
    logic [ST_W-1:0]   held_st;
    logic [RAIL_W-1:0] held_rail;
    logic [VSEL_W-1:0] held_vsel;

    // Link side: the reset is brought over by two flops, so sclk must fall at
    // least once during reset and twice after it before the first frame, or the
    // first bits of that frame are lost.
    always_comb begin
        l_n        = l;
        l_n.rst_s1 = rst_n;
        l_n.rst_s2 = l.rst_s1;
        if (!l.rst_s2) begin
            l_n.shift = LINK_RST.shift;
            l_n.tgl   = LINK_RST.tgl;
            l_n.out_bit = LINK_RST.out_bit;
        end else begin
            l_n.shift = {l.shift[FRAME_BITS-2:0], serial_in_pin};
            l_n.tgl   = ~l.tgl;
            l_n.out_bit = serial_in_pin;
        end
    end

    always_ff @(negedge sclk) begin
        l <= l_n;
    end

    // Core side.
    always_comb begin
        n       = r;
        n.cs_s1 = frame_select_pin;
        n.cs_s2 = r.cs_s1;
        n.cs_d  = r.cs_s2;
        n.cs_d2 = r.cs_d;
        n.tg_s1 = l.tgl;
        n.tg_s2 = r.tg_s1;
        n.tg_d  = r.tg_s2;
        n.st_req = 1'b0;
        set      = '0;
        commit_s = 1'b0;
        commit_v = 1'b0;
        // The shift word is read only after chip select has risen and the
        // last bit toggle has been seen, so it no longer moves.
        fr         = iwg_frame_t'(l.shift);
        eval       = r.cs_d && !r.cs_d2;
        len_ok     = r.bit_cnt == LEN_OK;
        par_ok     = ~^l.shift;
        wr_ok      = eval && !r.timed_out && len_ok && par_ok && fr.cmd;
        is_srr     = fr.addr == ADDR_SRR;
        is_srr_inv = fr.addr == ADDR_SRR_INV;
        is_pvr     = fr.addr == ADDR_PVR;
        is_pvr_inv = fr.addr == ADDR_PVR_INV;
        held_st    = r.held[ST_LSB +: ST_W];
        held_rail  = r.held[RAIL_LSB +: RAIL_W];
        held_vsel  = r.held[VSEL_LSB +: VSEL_W];
        srr_match  = r.pend == IWG_SRR_HELD && fr.data == ~r.held;
        pvr_match  = r.pend == IWG_PVR_HELD && fr.data[VSEL_LSB +: VSEL_W] == ~held_vsel;

        if (!r.cs_s2 && r.cs_d) begin
            n.bit_cnt   = '0;
            n.tmo_cnt   = '0;
            n.timed_out = 1'b0;
        end else begin
            if (r.tg_s2 != r.tg_d && r.bit_cnt != LEN_SAT) begin
                n.bit_cnt = r.bit_cnt + 5'h01;
            end
            if (!r.cs_s2 && !r.timed_out) begin
                if (r.tmo_cnt == TMO_W'(FRAME_MAX - 1)) begin
                    n.timed_out = 1'b1;
                    set.dur     = 1'b1;
                end else begin
                    n.tmo_cnt = r.tmo_cnt + TMO_W'(1);
                end
            end
        end

        // Length and parity faults are only judged once chip select is back high.
        if (eval && !r.timed_out) begin
            set.len = !len_ok;
            set.par = len_ok && !par_ok;
        end

        // Reads never touch a pending pair; only writes can break one.
        if (wr_ok) begin
            if (r.pend == IWG_SRR_HELD && !is_srr && !is_srr_inv) begin
                set.srr = 1'b1;
                n.pend  = IWG_IDLE;
            end
            if (r.pend == IWG_PVR_HELD && !is_pvr && !is_pvr_inv) begin
                set.volt = 1'b1;
                n.pend   = IWG_IDLE;
            end
            if (is_srr) begin
                n.held = fr.data;
                n.pend = IWG_SRR_HELD;
            end
            if (is_pvr) begin
                n.held = fr.data;
                n.pend = IWG_PVR_HELD;
            end
            if (is_srr_inv) begin
                n.pend = IWG_IDLE;
                if (srr_match) begin
                    commit_s = 1'b1;
                end else begin
                    set.srr = 1'b1;
                end
            end
            if (is_pvr_inv) begin
                n.pend = IWG_IDLE;
                if (pvr_match) begin
                    commit_v = 1'b1;
                end else begin
                    set.volt = 1'b1;
                end
            end
        end

        if (commit_s) begin
            n.rail = held_rail;
            if (transition_allowed[held_st]) begin
                n.st_req  = 1'b1;
                n.st_code = held_st;
            end
        end
        if (commit_v && voltage_code_allowed[held_vsel]) begin
            n.vsel = held_vsel;
        end

        // A new fault wins over a clear in the same cycle.
        n.flags  = (r.flags & ~flag_clear) | set;
        n.int_n  = ~|n.flags;
        n.out_en = !r.cs_s2 && !n.timed_out;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= CORE_RST;
        end else begin
            r <= n;
        end
    end

    assign serial_out_pin       = l.out_bit;
    assign serial_out_pin_oe    = r.out_en;
    assign state_request_pulse  = r.st_req;
    assign state_request_code   = r.st_code;
    assign rail_config          = r.rail;
    assign voltage_select_field = r.vsel;
    assign serial_error_flags   = r.flags;
    assign int_n                = r.int_n;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_srr_second;
        wr_ok && is_srr_inv && r.pend == IWG_SRR_HELD;
    endsequence

    sequence s_srr_good;
        s_srr_second ##0 fr.data == ~r.held;
    endsequence

    sequence s_pvr_good;
        wr_ok && is_pvr_inv && pvr_match;
    endsequence

    a_rail_commit: assert property (s_srr_good |=> rail_config == $past(held_rail))
        else $error("rail setting not applied from a good pair");

    a_rail_hold: assert property (!commit_s |=> $stable(rail_config))
        else $error("rail setting changed without a committed pair");

    a_mismatch_flag: assert property (
        s_srr_second ##0 fr.data != ~r.held |=> serial_error_flags.srr && $stable(rail_config))
        else $error("non-inverted second write not flagged");

    a_other_addr: assert property (
        wr_ok && r.pend == IWG_PVR_HELD && !is_pvr && !is_pvr_inv |=> serial_error_flags.volt)
        else $error("interrupting write did not break the voltage pair");

    a_trans_drop: assert property (
        s_srr_good ##0 !transition_allowed[held_st] |=> !state_request_pulse && !$rose(serial_error_flags.srr))
        else $error("disallowed transition was forwarded or flagged");

    a_volt_invalid: assert property (
        s_pvr_good ##0 !voltage_code_allowed[held_vsel] |=> $stable(voltage_select_field) && int_n == $past(int_n))
        else $error("invalid voltage code changed the setting or interrupted");

    a_pend_clear: assert property (wr_ok && (is_srr_inv || is_pvr_inv) |=> r.pend == IWG_IDLE)
        else $error("pending first write survived its pair");

    a_int_level: assert property ((|serial_error_flags) |-> !int_n)
        else $error("flag set without interrupt");

    a_parity_drop: assert property (
        eval && !r.timed_out && len_ok && !par_ok |=> serial_error_flags.par && $stable(rail_config)
            && $stable(r.pend))
        else $error("bad parity frame not ignored and flagged");

    a_flag_late: assert property ($rose(serial_error_flags.srr) |-> $past(eval))
        else $error("pair error raised before chip select rise");

    a_timeout_off: assert property ($rose(r.timed_out) |-> serial_error_flags.dur && !serial_out_pin_oe)
        else $error("frame timeout not flagged or output still driven");

    a_volt_commit: assert property (
        s_pvr_good ##0 voltage_code_allowed[held_vsel] |=> voltage_select_field == $past(held_vsel))
        else $error("valid voltage pair not applied");

    a_volt_hold: assert property (!commit_v |=> $stable(voltage_select_field))
        else $error("voltage setting changed without a committed pair");

    a_trans_fwd: assert property (
        s_srr_good ##0 transition_allowed[held_st] |=> state_request_pulse && state_request_code == $past(held_st))
        else $error("allowed transition not forwarded");

    a_pulse_single: assert property (state_request_pulse |=> !state_request_pulse)
        else $error("transition pulse longer than one cycle");

    a_srr_other: assert property (
        wr_ok && r.pend == IWG_SRR_HELD && !is_srr && !is_srr_inv |=> serial_error_flags.srr)
        else $error("interrupting write did not break the state and rail pair");

    a_volt_mismatch: assert property (
        wr_ok && is_pvr_inv && !pvr_match |=> serial_error_flags.volt && $stable(voltage_select_field))
        else $error("broken voltage pair not flagged or applied anyway");

    a_len_drop: assert property (
        eval && !r.timed_out && !len_ok |=> serial_error_flags.len && $stable(r.pend) && $stable(rail_config))
        else $error("frame of wrong length not ignored and flagged");

    a_vflag_late: assert property ($rose(serial_error_flags.volt) |-> $past(eval))
        else $error("voltage pair error raised before chip select rise");

    a_int_release: assert property (!(|serial_error_flags) |-> int_n)
        else $error("interrupt held with no flag set");
endmodule
`default_nettype wire

// *** dv/iwg_master.sv ***
// Serial master model that frames writes to the guard.
`timescale 1ns/1ps
`default_nettype none
module iwg_master (
    // Serial link
    output logic      sclk,
    output logic      frame_select_pin,
    output logic      serial_in_pin,
    input  wire logic serial_out_pin
);
    logic [15:0] echo;

    initial begin
        sclk = 1'b0;
        frame_select_pin = 1'b1;
        serial_in_pin = 1'b0;
        echo = '0;
    end

    // The master captures the loop-back on the falling edge.
    always @(negedge sclk) begin
        echo <= {echo[14:0], serial_out_pin};
    end

    // Clocks the link with the frame closed so the link reset can settle.
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
    endtask

    // Data changes after the rising edge so it is stable at the sampling fall.
    task automatic send(input logic [15:0] frame, input int nbits, input int hold_ns);
        frame_select_pin = 1'b0;
        #(160 + hold_ns);
        for (int i = 15; i > 15 - nbits; i--) begin
            #80 sclk = 1'b1;
            serial_in_pin = frame[i];
            #80 sclk = 1'b0;
        end
        #80 frame_select_pin = 1'b1;
        serial_in_pin = 1'b0;
        #400;
    endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the inverted-pair write guard.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import iwg_pkg::*;
    logic                   clk;
    logic                   rst_n;
    logic                   sclk;
    logic                   frame_select_pin;
    logic                   serial_in_pin;
    logic                   serial_out_pin;
    logic                   serial_out_pin_oe;
    logic [ST_CODES-1:0]    transition_allowed;
    logic [VSEL_CODES-1:0]  voltage_code_allowed;
    logic                   state_request_pulse;
    logic [ST_W-1:0]        state_request_code;
    logic [RAIL_W-1:0]      rail_config;
    logic [VSEL_W-1:0]      voltage_select_field;
    iwg_flags_t             flag_clear;
    iwg_flags_t             serial_error_flags;
    logic                   int_n;
    int                     n_fail;
    int                     samples_checked;
    int                     cyc = 0;
    int                     pulses = 0;
    logic [ST_W-1:0]        last_code = ST_RST;
    logic [ST_W-1:0]        exp_code;
    logic [RAIL_W-1:0]      exp_rail;
    logic [VSEL_W-1:0]      exp_vsel;
    logic [7:0]             b;

    // A released output line reads back inverted, so an undriven bit cannot pass the loop-back check.
    iwg_master m (.sclk(sclk), .frame_select_pin(frame_select_pin), .serial_in_pin(serial_in_pin),
                  .serial_out_pin(serial_out_pin_oe ? serial_out_pin : ~serial_out_pin));

    iwg_top #(.FRAME_MAX(200)) dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .frame_select_pin(frame_select_pin),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_pin_oe(serial_out_pin_oe),
        .transition_allowed(transition_allowed), .voltage_code_allowed(voltage_code_allowed),
        .state_request_pulse(state_request_pulse), .state_request_code(state_request_code),
        .rail_config(rail_config), .voltage_select_field(voltage_select_field), .flag_clear(flag_clear),
        .serial_error_flags(serial_error_flags), .int_n(int_n));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // A pulse wider than one cycle shows up as extra counts.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (state_request_pulse === 1'b1) begin
            pulses <= pulses + 1;
            last_code <= state_request_code;
        end
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    function automatic logic [15:0] frm(input logic [5:0] a, input logic [7:0] d);
        return {1'b1, a, d, ^{1'b1, a, d}};
    endfunction

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        m.send(frm(a, d), 16, 0);
        chk(16'(m.echo[14:0]), 16'(frm(a, d) >> 1), "loop-back");
    endtask

    task automatic srr_pair(input logic [7:0] d, input logic [7:0] mask);
        int p0;
        @(negedge clk) transition_allowed = mask;
        p0 = pulses;
        wr(ADDR_SRR, d);
        chk(16'(rail_config), 16'(exp_rail), "rail before second write");
        wr(ADDR_SRR_INV, ~d);
        exp_rail = d[7:3];
        if (mask[d[2:0]]) exp_code = d[2:0];
        chk(16'(rail_config), 16'(exp_rail), "rail");
        chk(16'(pulses - p0), 16'(mask[d[2:0]]), "pulse count");
        chk(16'(last_code), 16'(exp_code), "state code");
        chk(16'({serial_error_flags, int_n}), 16'h1, "flags after good pair");
    endtask

    task automatic volt_pair(input logic [7:0] v, input logic [3:0] hi, input logic [15:0] mask);
        @(negedge clk) voltage_code_allowed = mask;
        wr(ADDR_PVR, v);
        chk(16'(voltage_select_field), 16'(exp_vsel), "voltage before second write");
        wr(ADDR_PVR_INV, {hi, ~v[3:0]});
        if (mask[v[3:0]]) exp_vsel = v[3:0];
        chk(16'(voltage_select_field), 16'(exp_vsel), "voltage");
        chk(16'({serial_error_flags, int_n}), 16'h1, "flags after voltage pair");
    endtask

    task automatic err(input logic [4:0] exp_flags);
        chk(16'({serial_error_flags, int_n}), 16'({exp_flags, 1'b0}), "error flags");
        chk(16'({rail_config, voltage_select_field}), 16'({exp_rail, exp_vsel}), "outputs kept");
        @(negedge clk) flag_clear = '1;
        @(negedge clk) flag_clear = '0;
        repeat (3) @(negedge clk);
        chk(16'({serial_error_flags, int_n}), 16'h1, "flags cleared");
    endtask

    initial begin
        rst_n = 1'b0;
        transition_allowed = '0;
        voltage_code_allowed = '0;
        flag_clear = '0;
        n_fail = 0;
        samples_checked = 0;
        exp_rail = RAIL_RST;
        exp_vsel = VSEL_RST;
        exp_code = ST_RST;
        void'($urandom(32'h2816));
        // The link side leaves reset only on falling serial clock edges, two of them after release.
        fork
            m.idle_clocks(6);
        join_none
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (40) @(negedge clk);
        chk(16'({rail_config, voltage_select_field, state_request_code}), 16'h0, "reset outputs");
        chk(16'({serial_error_flags, int_n, serial_out_pin_oe}), 16'h2, "reset status");
        srr_pair(8'hff, 8'h00);
        srr_pair(8'h00, 8'hff);
        repeat (8) srr_pair(8'($urandom), 8'($urandom));
        volt_pair(8'h0f, 4'ha, 16'h7fff);
        repeat (8) volt_pair(8'($urandom), 4'($urandom), 16'($urandom));
        for (int k = 0; k < 8; k++) begin
            b = 8'($urandom);
            case (k)
                0: begin wr(ADDR_SRR, b); wr(ADDR_SRR_INV, b ^ 8'h81); end
                1: begin wr(ADDR_SRR, b); wr(6'h05, b); wr(ADDR_SRR_INV, ~b); end
                2: begin wr(ADDR_PVR, b); wr(ADDR_PVR_INV, {~b[7:4], b[3:0] ^ 4'h1}); end
                3: wr(ADDR_PVR_INV, ~b);
                4: m.send(frm(ADDR_SRR, b) ^ 16'h0001, 16, 0);
                5: m.send(frm(ADDR_SRR, b), 15, 0);
                6: m.send(frm(ADDR_PVR, b), 16, 5000);
                default: begin wr(ADDR_PVR, b); wr(6'h05, b); wr(ADDR_PVR_INV, ~b); end
            endcase
            case (k)
                0, 1: err(5'h01);
                4: err(5'h04);
                5: err(5'h08);
                6: err(5'h10);
                default: err(5'h02);
            endcase
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
